// ### design/frame_sync_generator.sv
// Frame sync generator and relay with AXI4-Lite register access
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "frame_sync_regs.svh"

module frame_sync_generator
   import frame_sync_pkg::*;
#(
   parameter int TICK_FAST = `TICK_FAST_CYC,
   parameter int TICK_SLOW = `TICK_SLOW_CYC
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [11:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [11:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic [7:0] sync_pin,
   output logic frame_timing_pulse,
   output logic [15:0] bc_slot_sync
);

   gen_s st;
   gen_s next_st;
   logic [7:0] pin_level;
   logic src_ext;
   logic gen_on;
   logic ext_pick;
   logic [1:0] port_sel;
   logic [10:0] tick_last;
   logic tick;
   logic [16:0] sum_len;
   logic [15:0] high_len;
   logic [15:0] low_len;
   logic [15:0] phase_len;

   // Map an address to a register index, or flag it unmapped
   function automatic logic [8:0] decode(input logic [11:0] addr);
      logic [7:0] idx;
      idx = addr[9:2];
      decode = {1'b0, idx};
      if (addr[1:0] == 2'b00 && addr[11:10] == 2'b00) begin
         case (idx)
            `IDX_CTRL, `IDX_HIGH_HI, `IDX_HIGH_LO, `IDX_LOW_HI, `IDX_LOW_LO,
            `IDX_ROUTE_A, `IDX_ROUTE_B, `IDX_RATE, `IDX_STATUS: decode = {1'b1, idx};
            default: decode = {1'b0, idx};
         endcase
      end
   endfunction

   // Phase of zero ticks is stretched to one; the >= compare would also end it on the first tick
   function automatic logic [15:0] at_least_one(input logic [15:0] v);
      at_least_one = (v == 16'h0000) ? 16'h0001 : v;
   endfunction

   sync_input_filter u_pin_filter (
      .clk(clk),
      .rst_n(rst_n),
      .pin_in(sync_pin),
      .level_out(pin_level)
   );

   // Source and tick selection
   always_comb begin
      src_ext = st.ctl[`CTL_SRC_EXT];
      gen_on = st.ctl[`CTL_GEN_ON] && !src_ext;
      ext_pick = pin_level[st.ctl[`CTL_SRC_MSB:`CTL_SRC_LSB]];
      port_sel = st.ctl[`CTL_SRC_LSB+1:`CTL_SRC_LSB];
      tick_last = st.rate[port_sel] ? 11'(TICK_SLOW - 1) : 11'(TICK_FAST - 1);
      tick = (st.gen != GEN_IDLE) && (st.tick_cnt >= tick_last);
      sum_len = {1'b0, st.high_cnt} + {1'b0, st.low_cnt};
      // Even split gives each phase half the summed counts, an odd tick dropped, in 50/50 mode
      high_len = st.ctl[`CTL_DUTY] ? at_least_one(sum_len[16:1]) : at_least_one(st.high_cnt);
      low_len = st.ctl[`CTL_DUTY] ? at_least_one(sum_len[16:1]) : at_least_one(st.low_cnt);
      phase_len = (st.gen == GEN_HIGH) ? high_len : low_len;
   end

   // Bus slave, generator and slot outputs
   always_comb begin
      logic [8:0] dec;
      dec = '0;
      next_st = st;
      // Write address and data are taken in either order
      if (awvalid && st.awready) begin
         next_st.aw_held = 1'b1;
         next_st.aw_addr = awaddr;
         next_st.awready = 1'b0;
      end
      if (wvalid && st.wready) begin
         next_st.w_held = 1'b1;
         next_st.wbyte = wdata[7:0];
         next_st.wlane = wstrb[0];
         next_st.wready = 1'b0;
      end
      if (st.aw_held && st.w_held) begin
         dec = decode(st.aw_addr);
         next_st.aw_held = 1'b0;
         next_st.w_held = 1'b0;
         next_st.bvalid = 1'b1;
         next_st.bresp = dec[8] ? `RESP_OKAY : `RESP_SLVERR;
         if (dec[8] && st.wlane) begin
            case (dec[7:0])
               `IDX_CTRL: next_st.ctl = {st.wbyte[7:4], 1'b0, st.wbyte[2:0]};
               `IDX_HIGH_HI: next_st.high_cnt[15:8] = st.wbyte;
               `IDX_HIGH_LO: next_st.high_cnt[7:0] = st.wbyte;
               `IDX_LOW_HI: next_st.low_cnt[15:8] = st.wbyte;
               `IDX_LOW_LO: next_st.low_cnt[7:0] = st.wbyte;
               `IDX_ROUTE_A: next_st.route_a = st.wbyte;
               `IDX_ROUTE_B: next_st.route_b = st.wbyte;
               `IDX_RATE: next_st.rate = st.wbyte[3:0];
               default: ;
            endcase
         end
      end
      if (st.bvalid && bready) begin
         next_st.bvalid = 1'b0;
         next_st.awready = 1'b1;
         next_st.wready = 1'b1;
      end
      // Reads answer one cycle after the address is taken
      if (arvalid && st.arready) begin
         dec = decode(araddr);
         next_st.arready = 1'b0;
         next_st.rvalid = 1'b1;
         next_st.rresp = dec[8] ? `RESP_OKAY : `RESP_SLVERR;
         case (dec[7:0])
            `IDX_CTRL: next_st.rdata = {24'h000000, st.ctl};
            `IDX_HIGH_HI: next_st.rdata = {24'h000000, st.high_cnt[15:8]};
            `IDX_HIGH_LO: next_st.rdata = {24'h000000, st.high_cnt[7:0]};
            `IDX_LOW_HI: next_st.rdata = {24'h000000, st.low_cnt[15:8]};
            `IDX_LOW_LO: next_st.rdata = {24'h000000, st.low_cnt[7:0]};
            `IDX_ROUTE_A: next_st.rdata = {24'h000000, st.route_a};
            `IDX_ROUTE_B: next_st.rdata = {24'h000000, st.route_b};
            `IDX_RATE: next_st.rdata = {28'h0000000, st.rate};
            `IDX_STATUS: next_st.rdata = {29'h0, src_ext, st.gen != GEN_IDLE, st.level};
            default: next_st.rdata = 32'h00000000;
         endcase
         if (!dec[8]) begin
            next_st.rdata = 32'h00000000;
         end
      end
      if (st.rvalid && rready) begin
         next_st.rvalid = 1'b0;
         next_st.arready = 1'b1;
      end
      // Generator phases
      case (st.gen)
         GEN_IDLE: begin
            next_st.tick_cnt = 11'h000;
            next_st.phase_cnt = 16'h0000;
            next_st.level = st.ctl[`CTL_START];
            if (gen_on) begin
               next_st.gen = st.ctl[`CTL_START] ? GEN_HIGH : GEN_LOW;
            end
         end
         GEN_HIGH, GEN_LOW: begin
            if (!gen_on) begin
               next_st.gen = GEN_IDLE;
               next_st.tick_cnt = 11'h000;
               next_st.phase_cnt = 16'h0000;
            end else if (tick) begin
               next_st.tick_cnt = 11'h000;
               if (st.phase_cnt + 16'h0001 >= phase_len) begin
                  // Phase done: flip level and keep running
                  next_st.phase_cnt = 16'h0000;
                  next_st.gen = (st.gen == GEN_HIGH) ? GEN_LOW : GEN_HIGH;
                  next_st.level = (st.gen == GEN_LOW);
               end else begin
                  next_st.phase_cnt = st.phase_cnt + 16'h0001;
               end
            end else begin
               next_st.tick_cnt = st.tick_cnt + 11'h001;
            end
         end
         default: next_st.gen = GEN_IDLE;
      endcase
      // External relay overrides the generator, which is off here
      if (src_ext) begin
         next_st.level = ext_pick;
      end
      // All four channels update on one edge, so skew stays bounded
      next_st.slots = {next_st.route_b, next_st.route_a} & {16{next_st.level}};
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st <= '0;
         st.awready <= 1'b1;
         st.wready <= 1'b1;
         st.arready <= 1'b1;
         st.ctl <= `CTRL_RST;
         st.high_cnt <= `COUNT_RST;
         st.low_cnt <= `COUNT_RST;
         st.route_a <= `ROUTE_RST;
         st.route_b <= `ROUTE_RST;
         st.rate <= `RATE_RST;
         st.gen <= GEN_IDLE;
      end else begin
         st <= next_st;
      end
   end

   // Outputs straight from state flops
   assign awready = st.awready;
   assign wready = st.wready;
   assign bvalid = st.bvalid;
   assign bresp = st.bresp;
   assign arready = st.arready;
   assign rvalid = st.rvalid;
   assign rresp = st.rresp;
   assign rdata = st.rdata;
   assign frame_timing_pulse = st.level;
   assign bc_slot_sync = st.slots;

   // Checker helpers: cycles between ticks and ticks spent high and low
   logic [10:0] gap;
   logic gap_seen;
   logic [15:0] hi_ticks;
   logic [15:0] lo_ticks;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         gap <= 11'h000;
         gap_seen <= 1'b0;
         hi_ticks <= 16'h0000;
         lo_ticks <= 16'h0000;
      end else begin
         gap <= tick ? 11'h001 : gap + 11'h001;
         // A rate or source change mid-gap gives one odd gap, so the watch restarts
         gap_seen <= (st.gen != GEN_IDLE) && (tick || gap_seen) && (st.rate == next_st.rate)
            && (st.ctl == next_st.ctl);
         hi_ticks <= (st.gen != GEN_HIGH) ? 16'h0000 : hi_ticks + {15'h0000, tick};
         lo_ticks <= (st.gen != GEN_LOW) ? 16'h0000 : lo_ticks + {15'h0000, tick};
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   property p_ext_relay;
      src_ext |=> frame_timing_pulse == $past(ext_pick) && st.gen == GEN_IDLE;
   endproperty
   a_ext_relay: assert property (p_ext_relay) else $error("external relay wrong");

   property p_slot_route;
      bc_slot_sync == ({st.route_b, st.route_a} & {16{frame_timing_pulse}});
   endproperty
   a_slot_route: assert property (p_slot_route) else $error("slot routing wrong");

   property p_idle_hold;
      !gen_on && !src_ext && st.gen == GEN_IDLE ##1 !src_ext
         |-> frame_timing_pulse == $past(st.ctl[`CTL_START]) && st.phase_cnt == 16'h0000;
   endproperty
   a_idle_hold: assert property (p_idle_hold) else $error("idle level wrong");

   property p_start_level;
      st.gen == GEN_IDLE && gen_on |=> st.gen != GEN_IDLE && frame_timing_pulse == $past(st.ctl[`CTL_START]);
   endproperty
   a_start_level: assert property (p_start_level) else $error("start level wrong");

   property p_tick_fast;
      tick && gap_seen && !st.rate[port_sel] |-> gap == 11'd60;
   endproperty
   a_tick_fast: assert property (p_tick_fast) else $error("fast tick not 600 ns");

   property p_tick_slow;
      tick && gap_seen && st.rate[port_sel] |-> gap == 11'd1200;
   endproperty
   a_tick_slow: assert property (p_tick_slow) else $error("slow tick not 12 us");

   property p_high_len;
      st.gen == GEN_HIGH && next_st.gen == GEN_LOW && !st.ctl[`CTL_DUTY] && $stable(st.high_cnt)
         |-> hi_ticks + 16'h0001 == at_least_one(st.high_cnt);
   endproperty
   a_high_len: assert property (p_high_len) else $error("high phase length wrong");

   // Phase lengths in ticks; a count that changes on the phase's last cycle is left unchecked
   property p_low_len;
      st.gen == GEN_LOW && next_st.gen == GEN_HIGH && !st.ctl[`CTL_DUTY] && $stable(st.low_cnt)
         |-> lo_ticks + 16'h0001 == at_least_one(st.low_cnt);
   endproperty
   a_low_len: assert property (p_low_len) else $error("low phase length wrong");

   // Even split: the high phase is half the summed counts
   property p_half_duty;
      st.gen == GEN_HIGH && next_st.gen == GEN_LOW && st.ctl[`CTL_DUTY]
         && $stable(st.high_cnt)
         && $stable(st.low_cnt)
         |-> hi_ticks + 16'h0001 == at_least_one(16'(({1'b0, st.high_cnt} + {1'b0, st.low_cnt}) >> 1));
   endproperty
   a_half_duty: assert property (p_half_duty) else $error("even split wrong");

   property p_keep_running;
      gen_on && st.gen != GEN_IDLE |=> st.gen != GEN_IDLE;
   endproperty
   a_keep_running: assert property (p_keep_running) else $error("generator stopped on its own");

   // Source zero must follow port 0's rate whatever the other ports run at
   property p_port_zero;
      tick && gap_seen && st.ctl[`CTL_SRC_EXT:`CTL_SRC_LSB] == 4'h0 |-> gap == (st.rate[0] ? 11'd1200 : 11'd60);
   endproperty
   a_port_zero: assert property (p_port_zero) else $error("source zero not timed by port 0");

   property p_ctrl_read;
      arvalid && arready && araddr == {2'b00, `IDX_CTRL, 2'b00} |=> rvalid && rdata[7:0] == $past(st.ctl);
   endproperty
   a_ctrl_read: assert property (p_ctrl_read) else $error("control read wrong");

   property p_bvalid_hold;
      bvalid && !bready |=> bvalid;
   endproperty
   a_bvalid_hold: assert property (p_bvalid_hold) else $error("write response dropped");

   c_ext_mode: cover property (src_ext ##1 $rose(frame_timing_pulse));
   c_full_period: cover property (st.gen == GEN_HIGH ##1 st.gen == GEN_LOW ##[1:1000] st.gen == GEN_HIGH);
   c_write: cover property (bvalid && bready && bresp == `RESP_OKAY);

endmodule

// ### design/frame_sync_pkg.sv
// Types shared by the frame sync generator and its pin filter
package frame_sync_pkg;

   // Generator phase, one-hot
   typedef enum logic [2:0] {
      GEN_IDLE = 3'b001,
      GEN_HIGH = 3'b010,
      GEN_LOW = 3'b100
   } gen_state_e;

   // Pin filter state: three stages and the accepted level
   typedef struct packed {
      logic [7:0] s1;
      logic [7:0] s2;
      logic [7:0] s3;
      logic [7:0] level;
   } filter_s;

   // Whole state of the generator top
   typedef struct packed {
      logic awready;
      logic wready;
      logic aw_held;
      logic w_held;
      logic [11:0] aw_addr;
      logic [7:0] wbyte;
      logic wlane;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic [7:0] ctl;
      logic [15:0] high_cnt;
      logic [15:0] low_cnt;
      logic [7:0] route_a;
      logic [7:0] route_b;
      logic [3:0] rate;
      gen_state_e gen;
      logic [10:0] tick_cnt;
      logic [15:0] phase_cnt;
      logic level;
      logic [15:0] slots;
   } gen_s;

endpackage

// ### design/frame_sync_regs.svh
// Register indices, field positions, reset values and timing counts of the frame sync generator
`ifndef FRAME_SYNC_REGS_SVH
`define FRAME_SYNC_REGS_SVH

// Register indices; byte address is four times the index
`define IDX_CTRL 8'h18
`define IDX_HIGH_HI 8'h19
`define IDX_HIGH_LO 8'h1a
`define IDX_LOW_HI 8'h1b
`define IDX_LOW_LO 8'h1c
`define IDX_ROUTE_A 8'h30
`define IDX_ROUTE_B 8'h31
`define IDX_RATE 8'h32
`define IDX_STATUS 8'h33

// Control register fields
`define CTL_GEN_ON 0
`define CTL_DUTY 1
`define CTL_START 2
`define CTL_SRC_EXT 7
`define CTL_SRC_MSB 6
`define CTL_SRC_LSB 4

// Reset values
`define CTRL_RST 8'h00
`define COUNT_RST 16'h0000
`define ROUTE_RST 8'h00
`define RATE_RST 4'h0

// AXI responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

// Timing
`define CLK_PERIOD_NS 10
`define TICK_FAST_NS 600
`define TICK_SLOW_NS 12000
`define TICK_FAST_CYC (`TICK_FAST_NS / `CLK_PERIOD_NS)
`define TICK_SLOW_CYC (`TICK_SLOW_NS / `CLK_PERIOD_NS)

`endif

// ### design/sync_input_filter.sv
// Three-stage synchroniser and agreement filter for the eight local sync pins
`timescale 1ns/1ns
module sync_input_filter
   import frame_sync_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [7:0] pin_in,
   output logic [7:0] level_out
);

   filter_s st;
   filter_s next_st;
   logic [7:0] next_level;

   // Per pin: accept a change only once stages two and three agree
   genvar i;
   generate
      for (i = 0; i < 8; i++) begin : g_pin
         assign next_level[i] = (st.s2[i] == st.s3[i]) ? st.s3[i] : st.level[i];
      end
   endgenerate

   // Stage one is read by stage two only
   always_comb begin
      next_st = st;
      next_st.s1 = pin_in;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      next_st.level = next_level;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign level_out = st.level;

endmodule

// ### testbench/bc_serializer_model.sv
// Far-side model: four serializers watching their back-channel sync slots
`timescale 1ns/1ns
module bc_serializer_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [15:0] bc_slot_sync,
   output int rises [4]
);
   logic [3:0] prev;

   // Each serializer counts rising sync edges on any of its four slots
   always_ff @(posedge clk) begin
      for (int p = 0; p < 4; p++) begin
         if (!rst_n) begin
            rises[p] <= 0;
         end else if (|bc_slot_sync[4*p +: 4] && !prev[p]) begin
            rises[p] <= rises[p] + 1;
         end
         prev[p] <= |bc_slot_sync[4*p +: 4];
      end
   end
endmodule

// ### testbench/test_frame_sync_generator.sv
// Self-checking bench for the frame sync generator
`timescale 1ns/1ns
module test_frame_sync_generator;
   localparam int TF = 60;
   localparam int TS = 1200;
   logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid, frame_timing_pulse;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, br;
   logic [7:0] sync_pin;
   logic [15:0] bc_slot_sync;
   int rises [4];
   int n_fail, n_tests, cyc, n;

   // Full tick counts kept so the design's own tick assertions stay valid
   frame_sync_generator #(.TICK_FAST(TF), .TICK_SLOW(TS)) DUT (
      .clk, .rst_n, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
      .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
      .rready, .sync_pin, .frame_timing_pulse, .bc_slot_sync
   );

   bc_serializer_model far_end (.clk, .rst_n, .bc_slot_sync, .rises);

   task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task end_of_test;
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   // Write one byte; each channel released at its own ready, response kept in br
   task wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge clk);
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      // Response left waiting one cycle so the slave must hold it
      bready <= 1'b1;
      do begin
         @(posedge clk);
      end while (bvalid !== 1'b1);
      br = bresp;
      bready <= 1'b0;
   endtask

   // Read one register and compare data and response
   task rd(input logic [11:0] a, input logic [7:0] e, input logic [1:0] er);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rready <= 1'b0;
      chk("rdata", rdata, {24'h0, e});
      chk("rresp", rresp, er);
   endtask

   // Cycles until the sync level next changes; bounded so a stuck level ends it
   task ph(output int c);
      logic old;
      old = frame_timing_pulse;
      c = 0;
      while (frame_timing_pulse === old && c < 6000) begin
         @(posedge clk);
         c++;
      end
   endtask

   task t_reset;
      chk("out", {frame_timing_pulse, bc_slot_sync}, 17'h0);
      rd(12'h060, 8'h00, 2'b00);
      rd(12'h064, 8'h00, 2'b00);
      rd(12'h06c, 8'h00, 2'b00);
      rd(12'h074, 8'h00, 2'b10);
      wr(12'h05c, 8'h55);
      chk("bresp", br, 2'b10);
   endtask

   // Port 0 fast while the others are slow, so a wrong port choice shows
   task t_gen_fast;
      wr(12'h0c0, 8'hff);
      wr(12'h0c4, 8'hff);
      wr(12'h0c8, 8'h0e);
      wr(12'h068, 8'h02);
      wr(12'h070, 8'h03);
      rd(12'h068, 8'h02, 2'b00);
      rd(12'h070, 8'h03, 2'b00);
      wr(12'h060, 8'h01);
      ph(n);
      chk("on", frame_timing_pulse, 1'b1);
      repeat (2) begin
         chk("slots", bc_slot_sync, 16'hffff);
         ph(n);
         chk("high", n, 2 * TF);
         chk("slots low", bc_slot_sync, 16'h0000);
         ph(n);
         chk("low", n, 3 * TF);
      end
      for (int p = 1; p < 4; p++) chk("rises", rises[p], rises[0]);
      chk("seen", rises[0] > 0, 1'b1);
   endtask

   task t_duty_slow;
      wr(12'h060, 8'h13);
      rd(12'h060, 8'h13, 2'b00);
      ph(n);
      ph(n);
      chk("half", n, 2 * TS);
      ph(n);
      chk("half", n, 2 * TS);
   endtask

   task t_idle;
      wr(12'h060, 8'h04);
      repeat (3) @(posedge clk);
      chk("idle", frame_timing_pulse, 1'b1);
      chk("idle slots", bc_slot_sync, 16'hffff);
      wr(12'h060, 8'h05);
      repeat (60) @(posedge clk);
      chk("start", frame_timing_pulse, 1'b1);
   endtask

   // Generator bit left set: a relayed pin must still win
   task t_ext;
      wr(12'h0c0, 8'h21);
      wr(12'h0c4, 8'h00);
      for (int k = 0; k < 8; k++) begin
         wr(12'h060, {1'b1, k[2:0], 4'h1});
         sync_pin <= 8'h01 << k;
         repeat (8) @(posedge clk);
         chk("relay", {frame_timing_pulse, bc_slot_sync}, {1'b1, 16'h0021});
         sync_pin <= ~(8'h01 << k);
         repeat (8) @(posedge clk);
         chk("relay", {frame_timing_pulse, bc_slot_sync}, 17'h0);
      end
      // Byte lane off: write answered but ignored
      wstrb <= 4'h0;
      wr(12'h060, 8'h00);
      wstrb <= 4'h1;
      chk("bresp", br, 2'b00);
      rd(12'h060, 8'hf1, 2'b00);
      rd(12'h0cc, 8'h04, 2'b00);
   endtask

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Hang guard, well above the longest expected run
   always @(posedge clk) begin
      cyc++;
      if (cyc == 40000) begin
         n_fail++;
         end_of_test;
      end
   end

   initial begin
      rst_n = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
      awaddr = 12'h0;
      araddr = 12'h0;
      wdata = 32'h0;
      wstrb = 4'h1;
      sync_pin = 8'h00;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      t_reset;
      t_gen_fast;
      t_duty_slow;
      t_idle;
      t_ext;
      end_of_test;
   end
endmodule
